// [gsc_electrode_model.sv]
`timescale 1ns/1ps
`default_nettype none
module gsc_electrode_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [2:0] tx_strobe_i,
   output logic [23:0] pulse_cnt_o
);
   // transmit switching seen per electrode
   always_ff @(posedge clk_i) begin
      for (int c = 0; c < 3; c++) begin
         if (rst_i) pulse_cnt_o[8*c+:8] <= 8'h00;
         else if (tx_strobe_i[c]) pulse_cnt_o[8*c+:8] <= pulse_cnt_o[8*c+:8] + 8'h01;
      end
   end
endmodule : gsc_electrode_model
`default_nettype wire

// [gsc_pkg.sv]
package gsc_pkg;
   // ****************************************
   // register indices (byte address = 4 x index)
   // ****************************************
   localparam logic [7:0] CH0_SETUP_A_IDX = 8'hA7;
   localparam logic [7:0] CH0_SETUP_B_IDX = 8'hA8;
   localparam logic [7:0] CH1_SETUP_A_IDX = 8'hB0;
   localparam logic [7:0] CH1_SETUP_B_IDX = 8'hB1;
   localparam logic [7:0] CH2_SETUP_A_IDX = 8'hB9;
   localparam logic [7:0] CH2_SETUP_B_IDX = 8'hBA;
   localparam logic [7:0] CH_STRIDE = 8'h09;
   localparam logic [7:0] STATUS_IDX = 8'hC0;
   localparam int NUM_CH = 3;
   localparam logic [15:0] SETUP_A_RST = 16'h0000;
   localparam logic [15:0] SETUP_B_RST = 16'h0000;
   // ****************************************
   // setup a, low byte
   // ****************************************
   localparam int A_CS_SIZE = 7;
   localparam int A_INACT_GND = 5;
   localparam int A_LINEAR = 4;
   localparam int A_TWO_SIDED = 3;
   localparam int A_FILT_OFF = 2;
   // high byte
   localparam int A_CCT_HI = 14;
   localparam int A_CCT_EN = 11;
   localparam int A_FREQ = 9;
   localparam int A_BAND = 8;
   // ****************************************
   // setup b
   // ****************************************
   localparam int B_LOAD_SIZE = 6;
   localparam int B_LOAD_EN = 5;
   localparam int B_MODE = 0;
   localparam int B_TXF = 12;
   localparam int B_INVERSE = 8;
   localparam int B_CCT_LO = 14;
   localparam logic [3:0] MODE_SELF = 4'h0;
   localparam logic [3:0] MODE_PROJ = 4'h1;
   // transmit pacing divider reload value
   localparam logic [2:0] TXDIV_1 = 3'h0;

   typedef struct packed {
      logic cap_large;
      logic inactive_ground;
      logic linearize;
      logic two_sided;
      logic filter_bypass;
      logic [3:0] charge_ext;
      logic [1:0] freq_code;
      logic narrow_band;
      logic [2:0] load_cap;
      logic self_mode;
      logic proj_mode;
      logic inverse_dir;
      logic [1:0] tx_code;
   } gsc_chcfg_t;
endpackage : gsc_pkg

// [gsc_sense_cfg.sv]
// Local design decision: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
module gsc_sense_cfg (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [31:0] adr_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   input wire logic [3:0] sel_i,
   input wire logic we_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   output logic ack_o,
   output logic err_o,
   input wire logic [2:0] tx_active_i,
   output logic [2:0] cap_large_o,
   output logic [2:0] inactive_ground_o,
   output logic [2:0] linearize_o,
   output logic [2:0] two_sided_o,
   output logic [2:0] fast_track_o,
   output logic [2:0] inverse_dir_o,
   output logic [2:0] filter_bypass_o,
   output logic [11:0] charge_ext_o,
   output logic [5:0] freq_code_o,
   output logic [2:0] narrow_band_o,
   output logic [5:0] load_code_o,
   output logic [2:0] load_en_o,
   output logic [2:0] self_mode_o,
   output logic [2:0] proj_mode_o,
   output logic [2:0] tx_strobe_o
);
   // ****************************************
   // registers
   // ****************************************
   localparam int NUM_CH = gsc_pkg::NUM_CH;

   logic [15:0] setup_a_r [NUM_CH];
   logic [15:0] setup_b_r [NUM_CH];
   logic [2:0] tx_cnt_r [NUM_CH];
   logic [7:0] idx;
   logic hit_a;
   logic hit_b;
   logic hit_st;
   logic [1:0] ch_sel;
   logic req;

   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                           input logic [3:0] s);
      merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
   endfunction : merge16

   function automatic logic [2:0] tx_limit(input logic [1:0] code);
      tx_limit = 3'((4'h1 << code) - 4'h1);
   endfunction : tx_limit

   assign idx = adr_i[9:2];
   assign req = cyc_i && stb_i && !ack_o && !err_o;

   // stride decode shared by all channels
   always_comb begin
      hit_a = 1'b0;
      hit_b = 1'b0;
      hit_st = (idx == gsc_pkg::STATUS_IDX) && (adr_i[31:10] == 22'h0) && (adr_i[1:0] == 2'h0);
      ch_sel = 2'h0;
      for (int c = 0; c < NUM_CH; c++) begin
         if (adr_i[31:10] == 22'h0 && adr_i[1:0] == 2'h0) begin
            if (idx == 8'(gsc_pkg::CH0_SETUP_A_IDX + 8'(c) * gsc_pkg::CH_STRIDE)) begin
               hit_a = 1'b1;
               ch_sel = 2'(c);
            end
            if (idx == 8'(gsc_pkg::CH0_SETUP_B_IDX + 8'(c) * gsc_pkg::CH_STRIDE)) begin
               hit_b = 1'b1;
               ch_sel = 2'(c);
            end
         end
      end
   end

   // ****************************************
   // wishbone slave: one wait state, ack or err
   // ****************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         err_o <= 1'b0;
      end else begin
         ack_o <= req && (hit_a || hit_b || (hit_st && !we_i));
         err_o <= req && !(hit_a || hit_b || (hit_st && !we_i));
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_o <= 32'h0000_0000;
      end else if (req) begin
         if (hit_a) begin
            dat_o <= {16'h0000, setup_a_r[ch_sel]};
         end else if (hit_b) begin
            dat_o <= {16'h0000, setup_b_r[ch_sel]};
         end else if (hit_st) begin
            dat_o <= {29'h0, tx_active_i & ~(3'h0)};
         end else begin
            dat_o <= 32'h0000_0000;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int c = 0; c < NUM_CH; c++) begin
            setup_a_r[c] <= gsc_pkg::SETUP_A_RST;
            setup_b_r[c] <= gsc_pkg::SETUP_B_RST;
         end
      end else if (req && we_i) begin
         if (hit_a) begin
            setup_a_r[ch_sel] <= merge16(setup_a_r[ch_sel], dat_i, sel_i);
         end
         if (hit_b) begin
            setup_b_r[ch_sel] <= merge16(setup_b_r[ch_sel], dat_i, sel_i);
         end
      end
   end

   // ****************************************
   // per-channel decode to sensing front end
   // ****************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cap_large_o <= 3'h0;
      end else begin
         for (int c = 0; c < NUM_CH; c++) begin
            cap_large_o[c] <= setup_a_r[c][gsc_pkg::A_CS_SIZE];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         inactive_ground_o <= 3'h0;
      end else begin
         for (int c = 0; c < NUM_CH; c++) begin
            inactive_ground_o[c] <= setup_a_r[c][gsc_pkg::A_INACT_GND];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         linearize_o <= 3'h0;
      end else begin
         for (int c = 0; c < NUM_CH; c++) begin
            linearize_o[c] <= setup_a_r[c][gsc_pkg::A_LINEAR];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         two_sided_o <= 3'h0;
      end else begin
         for (int c = 0; c < NUM_CH; c++) begin
            two_sided_o[c] <= setup_a_r[c][gsc_pkg::A_TWO_SIDED];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fast_track_o <= 3'h0;
      end else begin
         for (int c = 0; c < NUM_CH; c++) begin
            fast_track_o[c] <= !setup_a_r[c][gsc_pkg::A_TWO_SIDED];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         inverse_dir_o <= 3'h0;
      end else begin
         for (int c = 0; c < NUM_CH; c++) begin
            // linearized counts move the other way; inverse flips it again
            inverse_dir_o[c] <= setup_b_r[c][gsc_pkg::B_INVERSE] ^
                                setup_a_r[c][gsc_pkg::A_LINEAR];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         filter_bypass_o <= 3'h0;
      end else begin
         for (int c = 0; c < NUM_CH; c++) begin
            filter_bypass_o[c] <= setup_a_r[c][gsc_pkg::A_FILT_OFF];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         charge_ext_o <= 12'h000;
      end else begin
         for (int c = 0; c < NUM_CH; c++) begin
            charge_ext_o[c*4 +: 4] <= setup_a_r[c][gsc_pkg::A_CCT_EN] ?
               {setup_a_r[c][gsc_pkg::A_CCT_HI +: 2],
                setup_b_r[c][gsc_pkg::B_CCT_LO +: 2]} : 4'h0;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         freq_code_o <= 6'h00;
      end else begin
         for (int c = 0; c < NUM_CH; c++) begin
            freq_code_o[c*2 +: 2] <= setup_a_r[c][gsc_pkg::A_FREQ +: 2];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         narrow_band_o <= 3'h0;
      end else begin
         for (int c = 0; c < NUM_CH; c++) begin
            narrow_band_o[c] <= setup_a_r[c][gsc_pkg::A_BAND];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         load_code_o <= 6'h00;
      end else begin
         for (int c = 0; c < NUM_CH; c++) begin
            load_code_o[c*2 +: 2] <= setup_b_r[c][gsc_pkg::B_LOAD_SIZE +: 2];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         load_en_o <= 3'h0;
      end else begin
         for (int c = 0; c < NUM_CH; c++) begin
            load_en_o[c] <= setup_b_r[c][gsc_pkg::B_LOAD_EN];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         self_mode_o <= 3'h0;
      end else begin
         for (int c = 0; c < NUM_CH; c++) begin
            self_mode_o[c] <= setup_b_r[c][gsc_pkg::B_MODE +: 4] == gsc_pkg::MODE_SELF;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         proj_mode_o <= 3'h0;
      end else begin
         for (int c = 0; c < NUM_CH; c++) begin
            proj_mode_o[c] <= setup_b_r[c][gsc_pkg::B_MODE +: 4] == gsc_pkg::MODE_PROJ;
         end
      end
   end

   // ****************************************
   // transmit pin switching enables
   // ****************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_strobe_o <= 3'h0;
         for (int c = 0; c < NUM_CH; c++) begin
            tx_cnt_r[c] <= gsc_pkg::TXDIV_1;
         end
      end else begin
         for (int c = 0; c < NUM_CH; c++) begin
            if (!tx_active_i[c]) begin
               tx_cnt_r[c] <= gsc_pkg::TXDIV_1;
               tx_strobe_o[c] <= 1'b0;
            end else if (tx_cnt_r[c] >= tx_limit(setup_b_r[c][gsc_pkg::B_TXF +: 2])) begin
               tx_cnt_r[c] <= gsc_pkg::TXDIV_1;
               tx_strobe_o[c] <= 1'b1;
            end else begin
               tx_cnt_r[c] <= tx_cnt_r[c] + 3'h1;
               tx_strobe_o[c] <= 1'b0;
            end
         end
      end
   end
endmodule : gsc_sense_cfg
`default_nettype wire

// [gsc_sense_props.sv]
`timescale 1ns/1ps
`default_nettype none
module gsc_sense_props (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic ack_o,
   input wire logic err_o,
   input wire logic [2:0] tx_active_i,
   input wire logic [2:0] tx_strobe_o,
   input wire logic [2:0] cap_large_o,
   input wire logic [2:0] linearize_o,
   input wire logic [2:0] two_sided_o,
   input wire logic [2:0] fast_track_o,
   input wire logic [2:0] self_mode_o,
   input wire logic [2:0] proj_mode_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack too long");
   a_ack_follows: assert property (cyc_i && stb_i && !ack_o && !err_o |=> ack_o || err_o)
      else $error("no answer");
   a_no_stray: assert property (!(cyc_i && stb_i) |=> !ack_o && !err_o) else $error("stray ack");
   a_ack_err_excl: assert property (!(ack_o && err_o)) else $error("ack with err");
   a_fast_track: assert property ($stable(two_sided_o)[*3] |-> fast_track_o == ~two_sided_o)
      else $error("tracking mismatch");
   a_mode_excl: assert property ((self_mode_o & proj_mode_o) == 3'h0)
      else $error("two modes");
   a_strobe_idle: assert property ((tx_active_i == 3'h0)[*2] |-> tx_strobe_o == 3'h0)
      else $error("strobe while idle");
   a_cfg_written: assert property ($changed({cap_large_o, linearize_o}) |-> $past(ack_o))
      else $error("config moved without write");
endmodule : gsc_sense_props
bind gsc_sense_cfg gsc_sense_props i_props(.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
   .stb_i(stb_i), .ack_o(ack_o), .err_o(err_o), .tx_active_i(tx_active_i),
   .tx_strobe_o(tx_strobe_o), .cap_large_o(cap_large_o), .linearize_o(linearize_o),
   .two_sided_o(two_sided_o), .fast_track_o(fast_track_o), .self_mode_o(self_mode_o),
   .proj_mode_o(proj_mode_o));
`default_nettype wire

// [tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ack, err, e;
   logic [31:0] adr = 0, dat = 0, dq, rd;
   logic [3:0] sel = 0;
   logic [2:0] txa = 0, cl, ig, li, ts, ft, iv, fb, nb, le, sm, pm, st;
   logic [11:0] ce;
   logic [5:0] fc, lc;
   logic [23:0] pc, p0;
   logic [7:0] a2;
   int mismatches = 0, comparisons = 0, cycles = 0;
   always #4 clk_i = ~clk_i;
   gsc_sense_cfg i_dut(.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr), .dat_i(dat), .dat_o(dq),
      .sel_i(sel), .we_i(we), .cyc_i(cyc), .stb_i(stb), .ack_o(ack), .err_o(err),
      .tx_active_i(txa), .cap_large_o(cl), .inactive_ground_o(ig), .linearize_o(li),
      .two_sided_o(ts), .fast_track_o(ft), .inverse_dir_o(iv), .filter_bypass_o(fb),
      .charge_ext_o(ce), .freq_code_o(fc), .narrow_band_o(nb), .load_code_o(lc),
      .load_en_o(le), .self_mode_o(sm), .proj_mode_o(pm), .tx_strobe_o(st));
   gsc_electrode_model i_pads(.clk_i(clk_i), .rst_i(rst_i), .tx_strobe_i(st), .pulse_cnt_o(pc));
   task automatic summarize;
      $display("mismatches %0d comparisons %0d", mismatches, comparisons);
      if (mismatches == 0 && comparisons > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : summarize
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 6000) begin
         mismatches++;
         summarize();
      end
   end
   task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
      comparisons++;
      if (g !== x) begin
         mismatches++;
         $display("unexpected %s: expected %h seen %h", n, x, g);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [7:0] ix, input logic [15:0] d);
      @(posedge clk_i);
      cyc <= 1; stb <= 1; we <= w; sel <= 4'h3;
      adr <= {22'h0, ix, 2'h0};
      dat <= {16'h0, d};
      do @(posedge clk_i); while (ack !== 1'b1 && err !== 1'b1);
      e = err;
      rd = dq;
      cyc <= 0; stb <= 0; we <= 0;
   endtask : bus
   task automatic t_ch0;
      bus(1, gsc_pkg::CH0_SETUP_A_IDX, 16'hCFBC);
      bus(1, gsc_pkg::CH0_SETUP_B_IDX, 16'h61A1);
      @(posedge clk_i); #1;
      chk("ch0", 32'h79DF5, {cl[0], ig[0], li[0], ts[0], ft[0], iv[0], fb[0], ce[3:0], fc[1:0],
         nb[0], lc[1:0], le[0], sm[0], pm[0]});
      bus(0, gsc_pkg::CH0_SETUP_A_IDX, 16'h0000);
      chk("ch0 read", 32'h0000CFBC, rd);
   endtask : t_ch0
   task automatic t_ch2;
      a2 = gsc_pkg::CH0_SETUP_A_IDX + 8'h02 * gsc_pkg::CH_STRIDE;
      bus(1, a2, 16'hC010);
      bus(1, a2 + 8'h01, 16'h0100);
      @(posedge clk_i); #1;
      chk("ch2", 32'hA08, {li[2], ts[2], ft[2], iv[2], ce[11:8], sm[2], pm[2], le[2], nb[2]});
      chk("ch2 self load", 32'h0, {29'h0, le[2], 1'b0, pm[2]});
   endtask : t_ch2
   task automatic t_tx;
      txa <= 3'b010;
      for (int k = 0; k < 4; k++) begin
         bus(1, gsc_pkg::CH1_SETUP_B_IDX, {2'b00, 2'(k), 12'h000});
         repeat (8) @(posedge clk_i);
         p0 = pc;
         repeat (32) @(posedge clk_i);
         chk("ch1 strobes", 32'd32 >> k, {24'h0, pc[15:8] - p0[15:8]});
      end
      chk("ch0 strobes", 32'h0, {24'h0, pc[7:0]});
      bus(0, gsc_pkg::STATUS_IDX, 16'h0000);
      chk("status read", 32'h2, rd);
      txa <= 3'b000;
   endtask : t_tx
   task automatic t_err;
      bus(1, 8'h01, 16'hFFFF);
      chk("unmapped err", 32'h1, {31'h0, e});
      bus(1, gsc_pkg::STATUS_IDX, 16'hFFFF);
      chk("status err", 32'h1, {31'h0, e});
   endtask : t_err
   initial begin
      repeat (2) @(posedge clk_i);
      rst_i <= 0;
      t_ch0();
      t_ch2();
      t_tx();
      t_err();
      summarize();
   end
endmodule : tb_top
`default_nettype wire
